//--- ups_power_supervisor.sv
// supervisor sequencer: supply monitor, battery backup, led, handshake
// assumes synchronous inputs and an external threshold comparator result
`timescale 1ns/100ps
`default_nettype none
// Contract
// - bootloader idle 32 s resets by watchdog
// - host up gives steady 400 ms led
// - led solid while booting without handshake
// - cable and host alive blink every 400 ms
// - battery mode blinks once every 2 s, solid while host silent
// - 60 s on battery forces shutdown
// - backup engages within 10 us of loss; code engages at the next sample, up to 16 us
// - release backup after 3 s stable
// - switch off on battery shuts down, disconnects
// - answer slave addresses 0x68 through 0x6F
// - pulse train and shutdown on one line
// - sample supply every 16 us
// - fluctuation shortens sampling to 8 us
module ups_power_supervisor
	import ups_supervisor_pkg::*;
#(
	parameter int WDOG_CYC     = WDOG_S * CLK_HZ,
	parameter int STABLE_CYC   = STABLE_S * CLK_HZ,
	parameter int SHDN_CYC     = BAT_SHDN_S * CLK_HZ,
	parameter int FAST_WIN_CYC = FAST_WIN_MS * MS_CYC,
	parameter int REPLY_CYC    = REPLY_TO_MS * MS_CYC,
	parameter int HWAIT_CYC    = SHDN_WAIT_MS * MS_CYC,
	parameter int PULSE_CYC    = PULSE_MS * MS_CYC,
	parameter int OS_HALF_CYC  = (BLINK_OS_MS / 2) * MS_CYC,
	parameter int BAT_HALF_CYC = (BLINK_BAT_MS / 2) * MS_CYC
) (
	// clock and reset
	input  wire logic       MCLK,
	input  wire logic       RESET_N,
	// supply monitor: comparator says 5V pins are within threshold
	input  wire logic       SUPPLY_OK,
	// slide switch and its enable setting
	input  wire logic       SWITCH_ON,
	input  wire logic       SWITCH_ENABLE,
	// bootloader request and transfer start
	input  wire logic       BOOT_REQ,
	input  wire logic       BOOT_XFER,
	// host handshake
	input  wire logic       host_reply_in,
	output logic            shutdown_pulse_out,
	// slave address relocation and match
	input  wire logic [6:0] ADDR_BASE,
	input  wire logic       ADDR_LOAD,
	input  wire logic [6:0] I2C_ADDR,
	output logic            ADDR_HIT,
	// power path and indicators
	output logic            BACKUP_EN,
	output logic            BATTERY_DISC,
	output logic            STATUS_LED,
	output logic            WDOG_RESET
);
	// ============================================================
	// state
	mode_t       mode_q, mode_d;          // supervisor mode
	logic [31:0] tmr_q, tmr_d;            // mode timer
	logic [31:0] samp_q, samp_d;          // sample interval counter
	logic [31:0] fwin_q, fwin_d;          // fast-sampling window
	logic [31:0] stab_q, stab_d;          // stable-cable counter
	logic [31:0] rply_q, rply_d;          // reply timeout counter
	logic [31:0] blink_q, blink_d;        // led half-period counter
	logic [31:0] pls_q, pls_d;            // pulse train counter
	logic        ok_q, ok_d;              // last sampled supply level
	logic        alive_q, alive_d;        // host answering
	logic        rin_q, rin_d;            // previous reply level
	logic        arm_q, arm_d;            // skip edges in 1st cycle after reset
	logic [31:0] low_q, low_d;            // consecutive low supply cycles
	logic [6:0]  base_q, base_d;          // relocatable address base
	status_t     st_q, st_d;              // registered outputs
	logic        hit_q, hit_d;
	logic        sample;                  // sampling instant

	// ============================================================
	// supply monitor, sample pacing and handshake tracking
	always_comb begin
		samp_d  = samp_q + 32'd1;
		fwin_d  = (fwin_q != 32'd0) ? fwin_q - 32'd1 : 32'd0;
		sample  = (fwin_q == 32'd0) ? (samp_q >= 32'(SAMPLE_CYC - 1))
		// 8 us sampling in fluctuation window
		                            : (samp_q >= 32'(FAST_CYC - 1));
		if (sample) begin
			samp_d = 32'd0;
		end
		ok_d    = sample ? SUPPLY_OK : ok_q;
		if (sample && (SUPPLY_OK != ok_q)) begin
			fwin_d = 32'(FAST_WIN_CYC);  // fluctuation seen
		end
		// stability counted only over good samples
		stab_d  = !ok_q ? 32'd0 :
		          (stab_q < 32'(STABLE_CYC)) ? stab_q + 32'd1 : stab_q;
		rin_d   = host_reply_in;
		arm_d   = 1'b1;
		rply_d  = (arm_q && host_reply_in != rin_q) ? 32'd0 :
		          (rply_q < 32'(REPLY_CYC)) ? rply_q + 32'd1 : rply_q;
		alive_d = (arm_q && host_reply_in != rin_q) ? 1'b1 :
		          (rply_q >= 32'(REPLY_CYC)) ? 1'b0 : alive_q;
		low_d   = SUPPLY_OK ? 32'd0 :
		          (low_q < 32'(SAMPLE_CYC)) ? low_q + 32'd1 : low_q;
		base_d  = ADDR_LOAD ? ADDR_BASE : base_q;
		hit_d   = (I2C_ADDR >= base_q) &&
		          ({1'b0, I2C_ADDR} <= {1'b0, base_q} + {1'b0, ADDR_LAST_OFS});
	end

	// ============================================================
	// mode sequencer and outputs
	always_comb begin
		mode_d  = mode_q;
		tmr_d   = tmr_q + 32'd1;
		st_d    = st_q;
		blink_d = blink_q + 32'd1;
		pls_d   = (pls_q >= 32'(PULSE_CYC - 1)) ? 32'd0 : pls_q + 32'd1;
		st_d.wdog_reset = 1'b0;
		// loss seen at a sample engages backup at once
		if (sample && !SUPPLY_OK) begin
			st_d.backup_en = 1'b1;
		// release after stable time, never with a loss just seen
		end else if (ok_q && stab_q >= 32'(STABLE_CYC)) begin
			st_d.backup_en = 1'b0;
		end
		unique case (mode_q)
			M_BOOT, M_CABLE, M_BATTERY: begin
				if (BOOT_REQ) begin
					mode_d = M_BOOTLOADER;
					tmr_d  = 32'd0;
				end else if (!ok_q && mode_q != M_BATTERY) begin
					mode_d = M_BATTERY;
					tmr_d  = 32'd0;
				end else if (ok_q && mode_q == M_BATTERY) begin
					mode_d = alive_q ? M_CABLE : M_BOOT;
				end else if (mode_q == M_BOOT && alive_q) begin
					mode_d = M_CABLE;
				end else if (mode_q == M_CABLE && !alive_q) begin
					mode_d = M_BOOT;
				end
				// forced shutdown after 60 s on battery
				if (mode_q == M_BATTERY && tmr_q >= 32'(SHDN_CYC - 1)) begin
					mode_d = M_SHUTDOWN;
					tmr_d  = 32'd0;
				end
				// slide switch off while on battery
				if (mode_q == M_BATTERY && SWITCH_ENABLE && !SWITCH_ON) begin
					mode_d = M_SHUTDOWN;
					tmr_d  = 32'd0;
				end
			end
			M_SHUTDOWN: begin
				// cable return lets the host restart
				if (ok_q) begin
					mode_d = M_BOOT;
					st_d.battery_disc = 1'b0;
				// disconnect battery after host is down
				end else if (tmr_q >= 32'(HWAIT_CYC - 1)) begin
					st_d.battery_disc = 1'b1;
				end
			end
			M_BOOTLOADER: begin
				if (BOOT_XFER) begin
					tmr_d = 32'd0;
				end else if (tmr_q >= 32'(WDOG_CYC - 1)) begin
					st_d.wdog_reset = 1'b1;
					mode_d = M_BOOT;
				end
			end
		endcase
		// led pattern per mode
		case (mode_q)
			M_CABLE: begin
				if (blink_q >= 32'(OS_HALF_CYC - 1)) begin
					blink_d = 32'd0;
					st_d.led = ~st_q.led;
				end
			end
			M_BATTERY: begin
				if (!alive_q) begin
					st_d.led = 1'b1;
				end else if (blink_q >= 32'(BAT_HALF_CYC - 1)) begin
					blink_d = 32'd0;
					st_d.led = ~st_q.led;
				end
			end
			default: begin
				// solid led while booting or shutting down
				st_d.led = 1'b1;
				blink_d  = 32'd0;
			end
		endcase
		// pulse train, held high to request shutdown
		st_d.shdn_pulse = (mode_q == M_SHUTDOWN) ? 1'b1 :
		                  (pls_q < 32'(PULSE_CYC / 2));
	end

	// ============================================================
	// registers
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mode_q  <= M_BOOT;
			tmr_q   <= 32'd0;
			samp_q  <= 32'd0;
			fwin_q  <= 32'd0;
			stab_q  <= 32'd0;
			rply_q  <= 32'd0;
			blink_q <= 32'd0;
			pls_q   <= 32'd0;
			ok_q    <= 1'b1;
			alive_q <= 1'b0;
			rin_q   <= 1'b0;
			arm_q   <= 1'b0;
			low_q   <= 32'd0;
			base_q  <= ADDR_BASE_RST;
			st_q    <= '{backup_en: 1'b0, led: 1'b1, shdn_pulse: 1'b0,
			             battery_disc: 1'b0, wdog_reset: 1'b0};
			hit_q   <= 1'b0;
		end else begin
			mode_q  <= mode_d;
			tmr_q   <= tmr_d;
			samp_q  <= samp_d;
			fwin_q  <= fwin_d;
			stab_q  <= stab_d;
			rply_q  <= rply_d;
			blink_q <= blink_d;
			pls_q   <= pls_d;
			ok_q    <= ok_d;
			alive_q <= alive_d;
			rin_q   <= rin_d;
			arm_q   <= arm_d;
			low_q   <= low_d;
			base_q  <= base_d;
			st_q    <= st_d;
			hit_q   <= hit_d;
		end
	end

	assign BACKUP_EN          = st_q.backup_en;
	assign STATUS_LED         = st_q.led;
	assign shutdown_pulse_out = st_q.shdn_pulse;
	assign BATTERY_DISC       = st_q.battery_disc;
	assign WDOG_RESET         = st_q.wdog_reset;
	assign ADDR_HIT           = hit_q;

	// ============================================================
	// checks
	// a full sample interval of loss has engaged backup
	a_backup_fast: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(low_q >= 32'(SAMPLE_CYC)) |-> BACKUP_EN)
		else $error("backup not engaged in time");
	a_boot_led: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(mode_q == M_BOOT) |=> STATUS_LED)
		else $error("led not solid during boot");
	// watchdog pulse returns to normal mode
	a_wdog_exit: assert property (@(posedge MCLK) disable iff (!RESET_N)
		$rose(WDOG_RESET) |-> mode_q == M_BOOT)
		else $error("watchdog did not leave bootloader");
	// shutdown mode holds the line high
	a_shdn_line: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(mode_q == M_SHUTDOWN) |=> shutdown_pulse_out)
		else $error("shutdown request not driven");
	a_hold_backup: assert property (@(posedge MCLK) disable iff (!RESET_N)
		$fell(BACKUP_EN) |-> $past(stab_q) >= 32'(STABLE_CYC))
		else $error("backup released early");
	a_sample_gap: assert property (@(posedge MCLK) disable iff (!RESET_N)
		samp_q < 32'(SAMPLE_CYC))
		else $error("sample interval exceeded");
	// fluctuation window keeps the short interval
	a_fast_gap: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(fwin_q != 32'd0) |-> (samp_q < 32'(FAST_CYC)))
		else $error("fast sample interval exceeded");
	a_disc_mode: assert property (@(posedge MCLK) disable iff (!RESET_N)
		$rose(BATTERY_DISC) |-> $past(mode_q) == M_SHUTDOWN)
		else $error("battery disconnected outside shutdown");
	a_reply_to: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(rply_q >= 32'(REPLY_CYC)) && (host_reply_in == rin_q)
		|=> !alive_q)
		else $error("host still alive after timeout");
endmodule
`default_nettype wire

//--- ups_supervisor_pkg.sv
// constants, types and timing counts for the battery-backup supervisor
// assumes a single 20 MHz system clock
package ups_supervisor_pkg;
	// ============================================================
	// clock and timing
	localparam int CLK_HZ        = 20_000_000;
	localparam int CLK_NS        = 50;
	localparam int WDOG_S        = 32;   // bootloader transfer timeout
	localparam int BLINK_OS_MS   = 400;  // steady period once host is up
	localparam int BLINK_BAT_MS  = 2000; // one blink every 2 s on battery
	localparam int BAT_SHDN_S    = 60;   // forced shutdown on battery
	localparam int BACKUP_NS     = 10_000; // longest switch-over time
	localparam int STABLE_S      = 3;    // stable cable before release
	localparam int SAMPLE_US     = 16;   // normal sampling interval
	localparam int FAST_US       = 8;    // interval after a fluctuation
	localparam int FAST_WIN_MS   = 100;  // observation window
	localparam int REPLY_TO_MS   = 2000; // host reply timeout
	localparam int PULSE_MS      = 500;  // pulse train period
	localparam int SHDN_WAIT_MS  = 40_000; // host shutdown allowance
	// derived cycle counts; all divisions round down
	localparam int BACKUP_CYC   = BACKUP_NS / CLK_NS;
	localparam int SAMPLE_CYC   = SAMPLE_US * (CLK_HZ / 1_000_000);
	localparam int FAST_CYC     = FAST_US * (CLK_HZ / 1_000_000);
	localparam int MS_CYC       = CLK_HZ / 1000;
	// ============================================================
	// slave address block
	localparam logic [6:0] ADDR_BASE_RST = 7'h68;
	localparam logic [6:0] ADDR_LAST_OFS = 7'h07;
	// ============================================================
	// supervisor modes
	typedef enum logic [2:0] {
		M_BOOT, M_CABLE, M_BATTERY, M_SHUTDOWN, M_BOOTLOADER
	} mode_t;
	// status bundle reported to the top outputs
	typedef struct packed {
		logic backup_en;
		logic led;
		logic shdn_pulse;
		logic battery_disc;
		logic wdog_reset;
	} status_t;
endpackage

//--- ups_host_model.sv
// host computer model: echoes the supervisor's pulse train on the reply line
// assumes the bench's clock; enable low models a dead or absent daemon
`timescale 1ns/100ps
`default_nettype none
module ups_host_model #(
	parameter int DELAY = 2 // reply lag in cycles, 1 to 7
) (
	// clock and daemon running flag
	input  wire logic clk,
	input  wire logic enable,
	// handshake lines
	input  wire logic pulse,
	output logic      reply
);
	// ============================================================
	// echo logic
	logic [7:0] hist = 8'h00; // recent pulse line samples
	logic       rep  = 1'b0;  // reply level, one driver
	assign reply = rep;
	// a dead daemon leaves the line where it was: no edge, no reply
	always @(posedge clk) begin
		hist <= {hist[6:0], pulse};
		if (enable && hist[DELAY] != hist[DELAY-1])
			rep <= ~rep;
	end
endmodule
`default_nettype wire

//--- ups_power_supervisor_test.sv
// bench for the supervisor: boot, blink, backup, shutdown, watchdog, address
// assumes the host model beside it; long counts shortened by parameter
`timescale 1ns/100ps
`default_nettype none
module ups_power_supervisor_test;
	import ups_supervisor_pkg::*;
	// shortened counts; timing expectations derive from these
	localparam int H_OS = 20;
	localparam int H_BAT = 60;
	localparam int PUL = 40;
	localparam int SHDN = 1000;
	localparam int WDOG = 200;
	localparam int STAB = 100;
	localparam int REPLY = 300;
	localparam int HWAIT = 100;
	// ============================================================
	// signals
	logic       mclk, reset_n, supply_ok, switch_on, switch_en;
	logic       boot_req, boot_xfer, host_en, reply, pulse, addr_load, hit;
	logic [6:0] addr_base, i2c_addr;
	logic       backup, disc, led, wdog;
	int         bad_count, check_count, n;
	initial begin
		{mclk, reset_n, supply_ok, switch_on, switch_en} = 5'b00110;
		{boot_req, boot_xfer, host_en, addr_load} = 4'h0;
		addr_base = 7'h68;
		i2c_addr = 7'h00;
		bad_count = 0;
		check_count = 0;
	end
	always #25 mclk = ~mclk;
	// ============================================================
	// design and host
	ups_power_supervisor #(.WDOG_CYC(WDOG), .STABLE_CYC(STAB),
		.SHDN_CYC(SHDN), .FAST_WIN_CYC(400), .REPLY_CYC(REPLY),
		.HWAIT_CYC(HWAIT), .PULSE_CYC(PUL), .OS_HALF_CYC(H_OS),
		.BAT_HALF_CYC(H_BAT)) dut_u (.MCLK(mclk), .RESET_N(reset_n),
		.SUPPLY_OK(supply_ok), .SWITCH_ON(switch_on),
		.SWITCH_ENABLE(switch_en), .BOOT_REQ(boot_req),
		.BOOT_XFER(boot_xfer), .host_reply_in(reply),
		.shutdown_pulse_out(pulse), .ADDR_BASE(addr_base),
		.ADDR_LOAD(addr_load), .I2C_ADDR(i2c_addr), .ADDR_HIT(hit),
		.BACKUP_EN(backup), .BATTERY_DISC(disc), .STATUS_LED(led),
		.WDOG_RESET(wdog));
	ups_host_model host_u (.clk(mclk), .enable(host_en), .pulse(pulse),
		.reply(reply));
	// ============================================================
	// helpers: 0 led, 1 backup, 2 pulse line, 3 disconnect, 4 watchdog
	function automatic logic sig(input int w);
		case (w)
			0: return led;
			1: return backup;
			2: return pulse;
			3: return disc;
			default: return wdog;
		endcase
	endfunction
	task automatic chk(input string what, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic chk_n(input string what, input int e, input int g);
		check_count++;
		if (g != e) begin
			bad_count++;
			$display("MISMATCH %s expected %0d seen %0d", what, e, g);
		end
	endtask
	// bounded wait for a level; k is the cycles spent
	task automatic wait_val(input int w, input logic v, input int lim,
		output int k);
		k = 0;
		while (sig(w) !== v && k < lim) begin
			@(negedge mclk);
			k++;
		end
	endtask
	// cycles between two successive toggles
	task automatic gap(input int w, output int k);
		logic s;
		s = sig(w);
		wait_val(w, ~s, 500, k);
		wait_val(w, s, 500, k);
	endtask
	// count cycles that differ from v over len cycles
	task automatic hold(input int w, input logic v, input int len,
		output int k);
		k = 0;
		repeat (len) begin
			@(negedge mclk);
			if (sig(w) !== v)
				k++;
		end
	endtask
	task automatic do_reset;
		@(negedge mclk);
		{reset_n, host_en, supply_ok, switch_on} = 4'b0011;
		repeat (20) @(negedge mclk);
		reset_n = 1'b1;
	endtask
	task automatic go_alive;
		host_en = 1'b1;
		repeat (3 * PUL) @(negedge mclk);
	endtask
	task automatic go_battery;
		supply_ok = 1'b0;
		wait_val(1, 1'b1, 330, n);
		chk("backup engaged", 1'b1, backup);
	endtask
	// ============================================================
	// scenarios
	task automatic t_boot;
		do_reset();
		hold(0, 1'b1, 50, n);
		chk_n("led solid at boot", 0, n);
		chk("backup idle", 1'b0, backup);
	endtask
	task automatic t_addr;
		for (int a = 8'h66; a < 8'h72; a++) begin
			i2c_addr = a[6:0];
			@(negedge mclk);
			chk("default hit", a >= 8'h68 && a <= 8'h6F, hit);
		end
		addr_base = 7'h10;
		addr_load = 1'b1;
		@(negedge mclk);
		addr_load = 1'b0;
		for (int a = 8'h0F; a < 8'h19; a++) begin
			i2c_addr = a[6:0];
			@(negedge mclk);
			chk("moved hit", a >= 8'h10 && a <= 8'h17, hit);
		end
	endtask
	task automatic t_alive_battery;
		go_alive();
		gap(0, n);
		chk_n("led half period cable", H_OS, n);
		gap(2, n);
		chk_n("pulse half period", PUL / 2, n);
		go_battery();
		// switch moved without its enable is ignored
		switch_on = 1'b0;
		gap(0, n);
		chk_n("led half period battery", H_BAT, n);
		supply_ok = 1'b1;
		hold(1, 1'b1, STAB, n);
		chk_n("backup kept", 0, n);
		wait_val(1, 1'b0, 34000, n);
		chk("backup released", 1'b0, backup);
	endtask
	task automatic t_shutdown;
		do_reset();
		go_alive();
		go_battery();
		repeat (SHDN + 40) @(negedge mclk);
		hold(2, 1'b1, 2 * PUL, n);
		chk_n("forced shutdown line held", 0, n);
		supply_ok = 1'b1;
		wait_val(3, 1'b0, 340, n);
		chk("restart on cable return", 1'b0, disc);
	endtask
	task automatic t_switch;
		do_reset();
		switch_en = 1'b1; // enable before use
		go_alive();
		go_battery();
		switch_on = 1'b0;
		repeat (40) @(negedge mclk);
		chk("no early disconnect", 1'b0, disc);
		hold(0, 1'b1, PUL, n);
		chk_n("led solid on switch off", 0, n);
		wait_val(3, 1'b1, HWAIT + 100, n);
		chk("battery disconnected", 1'b1, disc);
		switch_en = 1'b0;
	endtask
	task automatic t_watchdog;
		do_reset();
		boot_req = 1'b1;
		@(negedge mclk);
		boot_req = 1'b0;
		wait_val(4, 1'b1, WDOG + 20, n);
		chk("watchdog fired", 1'b1, wdog);
		chk("watchdog not early", 1'b1, n >= WDOG - 2);
		do_reset();
		boot_req = 1'b1;
		@(negedge mclk);
		boot_req = 1'b0;
		repeat (WDOG / 2) @(negedge mclk);
		boot_xfer = 1'b1;
		@(negedge mclk);
		boot_xfer = 1'b0;
		hold(4, 1'b0, WDOG / 2 + 20, n);
		chk_n("transfer holds watchdog", 0, n);
	endtask
	task automatic t_host_lost;
		do_reset();
		go_alive();
		host_en = 1'b0;
		repeat (REPLY + 2 * H_OS + 20) @(negedge mclk);
		hold(0, 1'b1, 3 * H_OS, n);
		chk_n("led solid when host silent", 0, n);
	endtask
	// ============================================================
	// verdict, main sequence and watchdog
	task automatic results;
		if (bad_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		t_boot();
		t_addr();
		t_alive_battery();
		t_shutdown();
		t_switch();
		t_watchdog();
		t_host_lost();
		results();
	end
	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		results();
	end
endmodule
`default_nettype wire
